//--- logic/hal_pkg.sv
// Contract
// - The upper alarm turns on when the humidity reading is at or above the upper set level.
// - An active upper alarm stays on until the reading falls to the upper clear level.
// - The lower alarm turns on at or below the lower set level and turns off once the reading rises to the lower clear level.
// - Each of the four threshold registers is 14 bits wide and is compared directly with the 14-bit result.
// - Setup bits 8:7 configure the lower pin and bits 10:9 the upper pin, each on its own.
// - A polarity bit of 0 makes the asserted level high and a 1 makes it low.
// - A driver bit of 0 selects push-pull and a 1 selects open-drain, which only pulls low or releases.
// - With the lower pin inverted, the lower set level acts as a high-style clear level and the lower clear level as a high-style set level.
// - With the upper pin inverted, the two upper thresholds swap meaning, so the pin works as a low alarm.
// - In the pulse-density variant only the upper alarm works.
// - Setup bit 12 selects push-pull or open-drain for the ready pin, in the serial-bus variant only.
// - Setup bit 13 selects a command window of 10 ms when 0 and 3 ms when 1.
// - Upper thresholds reset to all ones and lower thresholds to zero.
// - Alarm evaluation follows each fresh conversion result.
package hal_pkg;
  localparam int          RES_W         = 14;
  localparam logic [3:0]  OFS_UP_SET    = 4'h0;
  localparam logic [3:0]  OFS_UP_CLR    = 4'h1;
  localparam logic [3:0]  OFS_LO_SET    = 4'h2;
  localparam logic [3:0]  OFS_LO_CLR    = 4'h3;
  localparam logic [3:0]  OFS_SETUP     = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h5;
  localparam logic [3:0]  OFS_MASK      = 4'h6;
  localparam logic [3:0]  OFS_RESULT    = 4'h7;
  localparam logic [13:0] RST_UP        = 14'h3FFF;
  localparam logic [13:0] RST_LO        = 14'h0000;
  localparam logic [15:0] RST_SETUP     = 16'h0028;
  localparam int          BIT_LO_POL    = 7;
  localparam int          BIT_LO_OD     = 8;
  localparam int          BIT_UP_POL    = 9;
  localparam int          BIT_UP_OD     = 10;
  localparam int          BIT_RDY_OD    = 12;
  localparam int          BIT_FAST      = 13;
  localparam int          ADDR_MSB      = 6;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          WIN_LONG_MS   = 10;
  localparam int          WIN_SHORT_MS  = 3;
  localparam int          WIN_LONG_CYC  = CLK_HZ / 1000 * WIN_LONG_MS;
  localparam int          WIN_SHORT_CYC = CLK_HZ / 1000 * WIN_SHORT_MS;
  localparam int          ST_UP_ON      = 0;
  localparam int          ST_UP_OFF     = 1;
  localparam int          ST_LO_ON      = 2;
  localparam int          ST_LO_OFF     = 3;
  localparam int          ST_W          = 4;
endpackage : hal_pkg

//--- logic/hal_hyst.sv
`timescale 1ns/100ps
module hal_hyst (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Result
  input  wire logic             res_vld,
  input  wire logic [hal_pkg::RES_W-1:0] res,
  // Thresholds after any swap, and the comparison style they are used with
  input  wire logic [hal_pkg::RES_W-1:0] on_lvl,
  input  wire logic [hal_pkg::RES_W-1:0] off_lvl,
  input  wire logic             low_style,
  // State
  output logic                  alarm_reg
);
  import hal_pkg::*;

  logic alarm_next;

  always_comb begin
    alarm_next = alarm_reg;
    if (!low_style) begin
      if (!alarm_reg && res >= on_lvl)
        alarm_next = 1'b1;
      else if (alarm_reg && res <= off_lvl)
        alarm_next = 1'b0;
    end else begin
      if (!alarm_reg && res <= on_lvl)
        alarm_next = 1'b1;
      else if (alarm_reg && res >= off_lvl)
        alarm_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      alarm_reg <= 1'b0;
    else if (res_vld)
      alarm_reg <= alarm_next;
  end
endmodule : hal_hyst

//--- logic/hal_pin.sv
`timescale 1ns/100ps
module hal_pin (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic state,
  input  wire logic invert,
  input  wire logic open_drain,
  input  wire logic enable,
  // Pin
  output logic      pin_o_reg,
  output logic      pin_oe_reg
);
  logic lvl;

  // Disabled pin rests high, so an open-drain driver lets it go
  assign lvl = enable ? (state ^ invert) : 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_o_reg  <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_o_reg  <= open_drain ? 1'b0 : lvl;
      pin_oe_reg <= open_drain ? !lvl : 1'b1;
    end
  end
endmodule : hal_pin

//--- logic/hal_top.sv
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module hal_top #(
  parameter bit PDM_VARIANT = 1'b0,
  parameter int WIN_LONG    = hal_pkg::WIN_LONG_CYC,
  parameter int WIN_SHORT   = hal_pkg::WIN_SHORT_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // Conversion result
  input  wire logic             res_vld,
  input  wire logic [hal_pkg::RES_W-1:0] res,
  // Alarm pins
  output logic                  up_pin_o,
  output logic                  up_pin_oe,
  output logic                  lo_pin_o,
  output logic                  lo_pin_oe,
  // Ready pin and setup decode
  input  wire logic             ready_in,
  output logic                  rdy_pin_o,
  output logic                  rdy_pin_oe,
  output logic [hal_pkg::ADDR_MSB:0] bus_slave_address,
  output logic                  cmd_window_open,
  // Interrupt
  output logic                  irq
);
  import hal_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [RES_W-1:0] up_set_reg, up_clr_reg, lo_set_reg, lo_clr_reg, res_reg;
  logic [15:0]      setup_reg;
  logic [ST_W-1:0]  status_reg, mask_reg, event_vec;
  logic             ack_reg;
  logic [23:0]      win_cnt_reg;
  logic             up_alarm, lo_alarm, up_prev_reg, lo_prev_reg;
  logic [3:0]       idx;
  logic             hit, wr_lo, wr_hi;

  assign idx   = avs_address[5:2];
  assign hit   = (avs_read || avs_write) && !ack_reg;
  // Writes land on the completing edge, while the master still holds them
  assign wr_lo = avs_write && ack_reg && avs_byteenable[0];
  assign wr_hi = avs_write && ack_reg && avs_byteenable[1];

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic lo, input logic hi);
    merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
  endfunction : merge16

  // One wait state: answer on the cycle after the request is seen
  always_ff @(posedge clk) begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_set_reg <= RST_UP;
      up_clr_reg <= RST_UP;
      lo_set_reg <= RST_LO;
      lo_clr_reg <= RST_LO;
      setup_reg  <= RST_SETUP;
      mask_reg   <= '0;
    end else if (wr_lo || wr_hi) begin
      unique case (idx)
        OFS_UP_SET: up_set_reg <= RES_W'(merge16({2'b00, up_set_reg}, avs_writedata, wr_lo, wr_hi));
        OFS_UP_CLR: up_clr_reg <= RES_W'(merge16({2'b00, up_clr_reg}, avs_writedata, wr_lo, wr_hi));
        OFS_LO_SET: lo_set_reg <= RES_W'(merge16({2'b00, lo_set_reg}, avs_writedata, wr_lo, wr_hi));
        OFS_LO_CLR: lo_clr_reg <= RES_W'(merge16({2'b00, lo_clr_reg}, avs_writedata, wr_lo, wr_hi));
        OFS_SETUP:  setup_reg  <= merge16(setup_reg, avs_writedata, wr_lo, wr_hi);
        OFS_MASK:   mask_reg   <= ST_W'(merge16({12'h000, mask_reg}, avs_writedata, wr_lo, wr_hi));
        default:    ;
      endcase
    end
  end

  // Read data is registered; unmapped words read zero
  always_ff @(posedge clk) begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && hit) begin
      unique case (idx)
        OFS_UP_SET: avs_readdata <= {18'h00000, up_set_reg};
        OFS_UP_CLR: avs_readdata <= {18'h00000, up_clr_reg};
        OFS_LO_SET: avs_readdata <= {18'h00000, lo_set_reg};
        OFS_LO_CLR: avs_readdata <= {18'h00000, lo_clr_reg};
        OFS_SETUP:  avs_readdata <= {16'h0000, setup_reg};
        OFS_STATUS: avs_readdata <= {28'h0000000, status_reg};
        OFS_MASK:   avs_readdata <= {28'h0000000, mask_reg};
        OFS_RESULT: avs_readdata <= {14'h0000, lo_alarm, up_alarm, 2'b00, res_reg};
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      res_reg <= RST_LO;
    else if (res_vld)
      res_reg <= res;
  end

  // ****************************************
  // Alarm evaluation
  // ****************************************
  logic up_inv, lo_inv, lo_en;
  assign up_inv = setup_reg[BIT_UP_POL];
  assign lo_inv = setup_reg[BIT_LO_POL];
  assign lo_en  = !PDM_VARIANT;

  // Inverted upper pin: pair swapped, low-style comparison
  hal_hyst u_up (
    .clk       (clk),
    .rst_n     (rst_n),
    .res_vld   (res_vld),
    .res       (res),
    .on_lvl    (up_inv ? up_clr_reg : up_set_reg),
    .off_lvl   (up_inv ? up_set_reg : up_clr_reg),
    .low_style (up_inv),
    .alarm_reg (up_alarm)
  );

  // Inverted lower pin: roles swap into a high-style alarm
  hal_hyst u_lo (
    .clk       (clk),
    .rst_n     (rst_n),
    .res_vld   (res_vld && lo_en),
    .res       (res),
    .on_lvl    (lo_inv ? lo_clr_reg : lo_set_reg),
    .off_lvl   (lo_inv ? lo_set_reg : lo_clr_reg),
    .low_style (!lo_inv),
    .alarm_reg (lo_alarm)
  );

  // ****************************************
  // Pins
  // ****************************************
  hal_pin u_up_pin (
    .clk        (clk),
    .rst_n      (rst_n),
    .state      (up_alarm),
    .invert     (up_inv),
    .open_drain (setup_reg[BIT_UP_OD]),
    .enable     (1'b1),
    .pin_o_reg  (up_pin_o),
    .pin_oe_reg (up_pin_oe)
  );

  hal_pin u_lo_pin (
    .clk        (clk),
    .rst_n      (rst_n),
    .state      (lo_alarm),
    .invert     (lo_inv),
    .open_drain (setup_reg[BIT_LO_OD] || PDM_VARIANT),
    .enable     (lo_en),
    .pin_o_reg  (lo_pin_o),
    .pin_oe_reg (lo_pin_oe)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdy_pin_o  <= 1'b0;
      rdy_pin_oe <= 1'b0;
    end else if (!PDM_VARIANT && setup_reg[BIT_RDY_OD]) begin
      rdy_pin_o  <= 1'b0;
      rdy_pin_oe <= !ready_in;
    end else begin
      rdy_pin_o  <= ready_in;
      rdy_pin_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      bus_slave_address <= RST_SETUP[ADDR_MSB:0];
    else
      bus_slave_address <= setup_reg[ADDR_MSB:0];
  end

  // Window counts from reset release; length read from setup at each cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_cnt_reg     <= '0;
      cmd_window_open <= 1'b0;
    end else begin
      if (32'(win_cnt_reg) < WIN_LONG)
        win_cnt_reg <= win_cnt_reg + 24'h000001;
      cmd_window_open <= 32'(win_cnt_reg) < (setup_reg[BIT_FAST] ? WIN_SHORT : WIN_LONG);
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_prev_reg <= 1'b0;
      lo_prev_reg <= 1'b0;
    end else begin
      up_prev_reg <= up_alarm;
      lo_prev_reg <= lo_alarm;
    end
  end

  assign event_vec = {lo_prev_reg & !lo_alarm, !lo_prev_reg & lo_alarm,
                      up_prev_reg & !up_alarm, !up_prev_reg & up_alarm};

  // Set wins over the clear-on-read
  always_ff @(posedge clk) begin
    if (!rst_n)
      status_reg <= '0;
    else if (avs_read && hit && idx == OFS_STATUS)
      status_reg <= event_vec;
    else
      status_reg <= status_reg | event_vec;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end
endmodule : hal_top

//--- tb/hal_load.sv
`timescale 1ns/100ps
// ****************
// Pull-up pin load
// ****************
module hal_load (
  // Driven side
  input  wire logic up_pin_o,
  input  wire logic up_pin_oe,
  input  wire logic lo_pin_o,
  input  wire logic lo_pin_oe,
  input  wire logic rdy_pin_o,
  input  wire logic rdy_pin_oe,
  // Wire levels
  output logic      up_lvl,
  output logic      lo_lvl,
  output logic      rdy_lvl
);
  // Released pin goes to the pull-up, never keeps its last value
  assign up_lvl  = up_pin_oe ? up_pin_o : 1'h1;
  assign lo_lvl  = lo_pin_oe ? lo_pin_o : 1'h1;
  assign rdy_lvl = rdy_pin_oe ? rdy_pin_o : 1'h1;
endmodule : hal_load

//--- tb/hal_assertions.sv
`timescale 1ns/100ps
module hal_chk #(
  parameter int WIN_LONG = 100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Causes
  input wire logic avs_write,
  input wire logic res_vld,
  // Watched outputs
  input wire logic up_pin_o,
  input wire logic up_pin_oe,
  input wire logic lo_pin_o,
  input wire logic lo_pin_oe,
  input wire logic cmd_window_open,
  input wire logic irq
);
  // *************
  // Cause history
  // *************
  int         run_cnt_reg;
  logic [4:0] ev_reg;
  logic       pin_cz;
  logic       irq_cz;
  // Kept through reset so that a release counts as a cause
  always_ff @(posedge clk) ev_reg <= {ev_reg[3:0], avs_write | res_vld | !rst_n};
  always_ff @(posedge clk) run_cnt_reg <= !rst_n ? 0 : run_cnt_reg + 1;
  assign pin_cz = |ev_reg[2:0];
  assign irq_cz = |ev_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_up_cause: assert property (!$stable(up_pin_o) |-> pin_cz) else $error("up pin moved");
  chk_up_drive: assert property (!$stable(up_pin_oe) |-> pin_cz) else $error("up oe moved");
  chk_lo_cause: assert property (!$stable(lo_pin_o) |-> pin_cz) else $error("lo pin moved");
  chk_lo_drive: assert property (!$stable(lo_pin_oe) |-> pin_cz) else $error("lo oe moved");
  chk_irq_cause: assert property ($rose(irq) |-> irq_cz) else $error("irq rose alone");
  chk_win_rise: assert property ($rose(cmd_window_open) |-> run_cnt_reg < 3) else $error("window late");
  chk_win_mid: assert property (run_cnt_reg == WIN_LONG / 2 |-> cmd_window_open) else $error("window shut");
  chk_win_len: assert property ($fell(cmd_window_open) |->
    run_cnt_reg >= WIN_LONG - 1 && run_cnt_reg <= WIN_LONG + 4) else $error("window length");
endmodule : hal_chk
bind hal_top hal_chk #(.WIN_LONG(WIN_LONG)) u_chk (.clk, .rst_n, .avs_write, .res_vld, .up_pin_o,
  .up_pin_oe, .lo_pin_o, .lo_pin_oe, .cmd_window_open, .irq);

//--- tb/hal_top_tb_top.sv
`timescale 1ns/100ps
module hal_top_tb_top;
  import hal_pkg::*;
  // *****************
  // Bench and devices
  // *****************
  localparam int WIN_L = 100;
  logic        clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, res_vld = 1'h0, ready_in = 1'h0;
  logic [5:0]  avs_address = 6'h00;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [13:0] res = 14'h0;
  logic [6:0]  bus_slave_address;
  logic        avs_waitrequest, up_pin_o, up_pin_oe, lo_pin_o, lo_pin_oe, rdy_pin_o, rdy_pin_oe;
  logic        cmd_window_open, irq, up_lvl, lo_lvl, rdy_lvl, up_pol = 1'h0, lo_pol = 1'h0, pin_od = 1'h0;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, win_cnt = 0;
  hal_top #(.WIN_LONG(WIN_L), .WIN_SHORT(30)) DUT (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .res_vld, .res, .up_pin_o,
    .up_pin_oe, .lo_pin_o, .lo_pin_oe, .ready_in, .rdy_pin_o, .rdy_pin_oe, .bus_slave_address,
    .cmd_window_open, .irq);
  hal_load LOAD (.up_pin_o, .up_pin_oe, .lo_pin_o, .lo_pin_oe, .rdy_pin_o, .rdy_pin_oe, .up_lvl, .lo_lvl,
    .rdy_lvl);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_n && cmd_window_open === 1'h1) win_cnt <= win_cnt + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Wait until waitrequest drops; only the bench timeout limits this wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus
  task automatic step(input logic [13:0] v, input logic u, input logic l);
    logic [31:0] q;
    @(posedge clk);
    res <= v;
    res_vld <= 1'h1;
    @(posedge clk);
    res_vld <= 1'h0;
    repeat (4) @(posedge clk);
    bus(1'h0, OFS_RESULT, 32'h0, q);
    cmp("state", {14'h0, l, u, 2'h0, v}, q);
    cmp("up_lvl", {31'h0, u ^ up_pol}, {31'h0, up_lvl});
    cmp("lo_lvl", {31'h0, l ^ lo_pol}, {31'h0, lo_lvl});
    cmp("up_oe", {31'h0, !pin_od | !(u ^ up_pol)}, {31'h0, up_pin_oe});
    cmp("lo_oe", {31'h0, !pin_od | !(l ^ lo_pol)}, {31'h0, lo_pin_oe});
  endtask : step
  task automatic t_reset();
    logic [31:0] q;
    for (int i = 0; i < 5; i++) begin
      bus(1'h0, i[3:0], 32'h0, q);
      cmp("reset_val", i == 4 ? {16'h0, RST_SETUP} : {18'h0, i < 2 ? RST_UP : RST_LO}, q);
    end
    cmp("slave_addr", 32'h28, {25'h0, bus_slave_address});
    bus(1'h1, OFS_UP_SET, 32'hFFFF_C000, q);
    bus(1'h0, OFS_UP_SET, 32'h0, q);
    cmp("width", 32'h0, q);
    bus(1'h1, 4'hF, 32'hFFFF, q);
    bus(1'h0, 4'hF, 32'h0, q);
    cmp("unmapped", 32'h0, q);
    avs_byteenable <= 4'h1;
    bus(1'h1, OFS_LO_CLR, 32'h0000_3FFF, q);
    avs_byteenable <= 4'h3;
    bus(1'h0, OFS_LO_CLR, 32'h0, q);
    cmp("byte_lane", 32'hFF, q);
  endtask : t_reset
  task automatic t_norm();
    logic [31:0] q;
    bus(1'h1, OFS_UP_SET, 32'h2000, q);
    bus(1'h1, OFS_UP_CLR, 32'h1000, q);
    bus(1'h1, OFS_LO_SET, 32'h0800, q);
    bus(1'h1, OFS_LO_CLR, 32'h0C00, q);
    step(14'h1FFF, 1'h0, 1'h0);
    step(14'h2000, 1'h1, 1'h0);
    step(14'h1001, 1'h1, 1'h0);
    step(14'h1000, 1'h0, 1'h0);
    step(14'h0801, 1'h0, 1'h0);
    step(14'h0800, 1'h0, 1'h1);
    step(14'h0BFF, 1'h0, 1'h1);
    step(14'h0C00, 1'h0, 1'h0);
  endtask : t_norm
  task automatic t_inv();
    logic [31:0] q;
    bus(1'h1, OFS_SETUP, 32'h02A8, q);
    up_pol = 1'h1;
    lo_pol = 1'h1;
    step(14'h0C00, 1'h1, 1'h1);
    step(14'h1800, 1'h1, 1'h1);
    step(14'h2000, 1'h0, 1'h1);
    step(14'h0800, 1'h1, 1'h0);
  endtask : t_inv
  task automatic t_od_irq();
    logic [31:0] q;
    bus(1'h1, OFS_SETUP, 32'h1528, q);
    {up_pol, lo_pol, pin_od} = 3'h1;
    step(14'h1000, 1'h0, 1'h0);
    bus(1'h0, OFS_STATUS, 32'h0, q);
    bus(1'h1, OFS_MASK, 32'h1, q);
    step(14'h2000, 1'h1, 1'h0);
    cmp("irq", 32'h1, {31'h0, irq});
    bus(1'h0, OFS_STATUS, 32'h0, q);
    cmp("status", 32'h1, q);
    repeat (4) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    // Masked off event must stay quiet
    step(14'h1000, 1'h0, 1'h0);
    cmp("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ready_in <= i[0];
      repeat (3) @(posedge clk);
      cmp("rdy_oe", {31'h0, !i[0]}, {31'h0, rdy_pin_oe});
      cmp("rdy_lvl", {31'h0, i[0]}, {31'h0, rdy_lvl});
    end
  endtask : t_od_irq
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_norm();
    t_inv();
    t_od_irq();
    cmp("window", WIN_L, win_cnt);
    end_of_test();
  end
endmodule : hal_top_tb_top
